// file: core/arb_fifo.sv
// Small valid/ready FIFO that stages encoded words ahead of the main buffer.
`timescale 1ns/100ps
module arb_fifo
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
)
(
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             nrst,
    // Filling side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];   // Word storage.
    logic [AW-1:0]    wr_ptr;        // Write index.
    logic [AW-1:0]    rd_ptr;        // Read index.
    logic [AW:0]      count;         // Words held.
    logic             push;
    logic             pop;
    logic [AW:0]      next_count;    // Occupancy after this cycle.

    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage write.
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and occupancy.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
        end
    end

    // Space flag kept in a flip-flop, so the filling side sees a clean ready.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            in_ready <= 1'b0;
        end
        else
        begin
            in_ready <= (next_count != (AW+1)'(DEPTH));
        end
    end
endmodule

// file: core/arb_pkg.sv
// Types for the ADPCM record buffer readout block.
package arb_pkg;
    // Meaning of the two host-data registers.
    typedef enum logic [0:0]
    {
        ARB_MODE_IDLE   = 1'b0,
        ARB_MODE_RECORD = 1'b1
    } arb_mode_t;
endpackage

// file: core/arb_regs.svh
// Constants for the ADPCM record buffer readout block.
`ifndef ARB_REGS_SVH
`define ARB_REGS_SVH
`define ARB_BUF_DEPTH    1024
`define ARB_WORD_W       16
`define ARB_BLOCK_WORDS  128
`define ARB_FIFO_DEPTH   16
`define ARB_CNT_W        11
`define ARB_ZERO_WORD_POS 1
`endif

// file: core/arb_top.sv
// Record buffer: encoder words in, host pops from data port, fill count out.
`timescale 1ns/100ps
`include "arb_regs.svh"
module arb_top
    import arb_pkg::*;
#(
    parameter int DEPTH = `ARB_BUF_DEPTH,
    parameter int WW    = `ARB_WORD_W
)
(
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // Mode control from the control register.
    input  wire logic                  record_enable_bit,
    input  wire logic                  soft_reset_bit,
    // Encoder word stream.
    input  wire logic                  enc_valid,
    output logic                       enc_ready,
    input  wire logic [WW-1:0]         enc_data,
    // Host data port.
    input  wire logic                  host_rd,
    output logic [WW-1:0]              encoded_word_port,
    output logic [`ARB_CNT_W-1:0]      buffer_fill_count,
    output logic                       record_active,
    output logic                       overflow_pulse
);
    localparam int AW = $clog2(DEPTH);             // Buffer index width.
    localparam int BW = $clog2(`ARB_BLOCK_WORDS);  // Block position width.
    arb_mode_t       mode;                    // Register meaning.
    logic [WW-1:0]   mem [DEPTH];             // Main buffer.
    logic [AW-1:0]   wr_ptr;                  // Next slot to fill.
    logic [AW-1:0]   rd_ptr;                  // Slot of the oldest word.
    logic [AW:0]     count;                   // Words held.
    logic [BW-1:0]   blk_pos;                 // Position of the next word in its block.
    logic            f_valid;                 // Staging FIFO holds a word.
    logic            f_ready;                 // Buffer takes staged words.
    logic [WW-1:0]   f_data;                  // Oldest staged word.
    logic            push;                    // A staged word moves on this cycle.
    logic            pop;                     // A host read takes effect this cycle.
    logic            full;                    // Buffer at capacity.
    logic            store;                   // A word is written into storage.
    logic [WW-1:0]   store_word;              // The word as it is stored.

    // Decodes whether the host registers carry recording data.
    function automatic logic is_record(input arb_mode_t m);
        return (m == ARB_MODE_RECORD);
    endfunction

    // ==========================================
    // Staging and handshake
    // ==========================================
    // Staging FIFO; back-pressure stalls the encoder while not recording.
    arb_fifo #(.WIDTH(WW), .DEPTH(`ARB_FIFO_DEPTH)) u_fifo
    (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (enc_valid),
        .in_ready  (enc_ready),
        .in_data   (enc_data),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    assign full    = (count == (AW+1)'(DEPTH));
    assign f_ready = is_record(mode);
    assign push    = f_valid && f_ready;
    assign pop     = host_rd && (count != '0) && is_record(mode);
    assign store   = push && !full;

    // The fourth byte of every block leaves as zero; a file built from the
    // stream then keeps the marker that players and hosts check for.
    assign store_word = (blk_pos == BW'(`ARB_ZERO_WORD_POS))
                      ? {f_data[WW-1:8], 8'h00} : f_data;

    // ==========================================
    // Block framing
    // ==========================================
    // Counts stored words modulo the block length; the count wraps by itself
    // because the block length is a power of two. It restarts with the
    // buffer, so the first word after a clear always opens a block.
    always_ff @(posedge clk)
    begin
        if (!nrst || soft_reset_bit)
        begin
            // Fresh recording: first word opens a block.
            blk_pos <= '0;
        end
        else if (push && full)
        begin
            // Overflow drops the buffer and the partial block with it.
            blk_pos <= '0;
        end
        else if (store)
        begin
            // One more word of the current block.
            blk_pos <= blk_pos + 1'b1;
        end
    end

    // ==========================================
    // Register meaning
    // ==========================================
    // Mode: recording entered by soft reset with enable set.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            mode <= ARB_MODE_IDLE;
        end
        else if (soft_reset_bit)
        begin
            mode <= record_enable_bit ? ARB_MODE_RECORD : ARB_MODE_IDLE;
        end
    end

    // Buffer storage write.
    always_ff @(posedge clk)
    begin
        // Words keep their order, so the drained stream plays back as made.
        if (store)
        begin
            mem[wr_ptr] <= store_word;
        end
    end

    // ==========================================
    // Occupancy
    // ==========================================
    // Pointers and fill; a push into a full buffer empties it.
    always_ff @(posedge clk)
    begin
        if (!nrst || soft_reset_bit)
        begin
            wr_ptr         <= '0;
            rd_ptr         <= '0;
            count          <= '0;
            overflow_pulse <= 1'b0;
        end
        else if (push && full)
        begin
            wr_ptr         <= '0;
            rd_ptr         <= '0;
            count          <= '0;
            overflow_pulse <= 1'b1;
        end
        else
        begin
            overflow_pulse <= 1'b0;
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // ==========================================
    // Host view
    // ==========================================
    // Registered host view; zero while recording is off.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            // Everything the host sees starts at zero.
            encoded_word_port <= '0;
            buffer_fill_count <= '0;
            record_active     <= 1'b0;
        end
        else
        begin
            // Data port shows the oldest word; fill count only while recording.
            record_active     <= is_record(mode);
            buffer_fill_count <= is_record(mode) ? `ARB_CNT_W'(count) : '0;
            encoded_word_port <= (count != '0) ? mem[rd_ptr] : '0;
        end
    end

    // ==========================================
    // Checks
    // ==========================================
    chk_count_bound: assert property (
        @(posedge clk) disable iff (!nrst) count <= (AW+1)'(DEPTH))
        else $error("fill above capacity");
    chk_pop_lowers: assert property (
        @(posedge clk) disable iff (!nrst)
        (pop && !push && !soft_reset_bit) |=> count == $past(count) - 1'b1)
        else $error("pop did not lower count");
    chk_ovf_empty: assert property (
        @(posedge clk) disable iff (!nrst)
        (push && full && !soft_reset_bit) |=> (count == '0 && overflow_pulse))
        else $error("overflow did not empty");
    chk_ovf_single: assert property (
        @(posedge clk) disable iff (!nrst)
        overflow_pulse |=> !overflow_pulse)
        else $error("overflow pulse too long");
    chk_fill_report: assert property (
        @(posedge clk) disable iff (!nrst)
        (mode == ARB_MODE_RECORD) |=> buffer_fill_count == `ARB_CNT_W'($past(count)))
        else $error("fill count mismatch");
    chk_idle_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        (mode == ARB_MODE_IDLE) |=> buffer_fill_count == '0)
        else $error("count shown while idle");
    chk_soft_clear: assert property (
        @(posedge clk) disable iff (!nrst)
        soft_reset_bit |=> (count == '0 && !overflow_pulse))
        else $error("soft reset did not clear");
    cov_overflow: cover property (@(posedge clk) disable iff (!nrst) overflow_pulse);
    cov_drain: cover property (@(posedge clk) disable iff (!nrst) pop ##1 count == '0);
    cov_record: cover property (@(posedge clk) disable iff (!nrst) $rose(record_active));
    cov_zero_slot: cover property (@(posedge clk) disable iff (!nrst)
        store && blk_pos == BW'(`ARB_ZERO_WORD_POS));
endmodule

// file: test/adpcm_record_buffer_readout_tb_top.sv
// Bench for the record buffer: fill, drain, capacity and overflow.
`timescale 1ns/100ps
module adpcm_record_buffer_readout_tb_top;
    import arb_pkg::*;
    // Row of the fill table: words pushed and the count they give.
    typedef struct {int n; logic [15:0] base; logic [10:0] cnt;} arb_row_t;
    logic        clk = 1'b0;    // Bench clock.
    logic        nrst = 1'b0;   // Synchronous reset, active low.
    logic        rec = 1'b0;    // Record enable level.
    logic        srst = 1'b0;   // Soft reset level.
    logic        ev = 1'b0;     // Encoder valid.
    logic [15:0] ed = 16'h0000; // Encoder data.
    logic        host_en = 1'b0;
    logic        er, rd, act, ovf, got_v, ovf_seen = 1'b0, acc;
    logic [15:0] port, got;
    logic [10:0] cnt;
    logic [15:0] exp[$];        // Words the host should see, oldest first.
    int          mismatches = 0;
    int          checks_done = 0;
    int          blk = 0;       // Position of the next pushed word in its block.
    arb_row_t    rows[3] = '{'{1, 16'h1a00, 11'h001}, '{5, 16'h2b00, 11'h005},
                             '{32, 16'h3c00, 11'h020}};
    // Clock at 125 MHz.
    always #4 clk = ~clk;
    arb_top #(.DEPTH(32)) dut_u (.clk(clk), .nrst(nrst), .record_enable_bit(rec),
        .soft_reset_bit(srst), .enc_valid(ev), .enc_ready(er), .enc_data(ed),
        .host_rd(rd), .encoded_word_port(port), .buffer_fill_count(cnt),
        .record_active(act), .overflow_pulse(ovf));
    arb_host_model host_u (.clk(clk), .en(host_en), .word_in(port), .fill(cnt),
        .rd(rd), .got(got), .got_v(got_v));
    // ==========================================
    // Checking helpers
    // ==========================================
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Compares one value with its expectation.
    task automatic cmp(input logic [15:0] a, input logic [15:0] e);
        checks_done++;
        if (a !== e)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, a, e);
        end
    endtask
    // Compares a fill count with its expectation.
    task automatic cmp_count(input logic [10:0] a, input logic [10:0] e);
        cmp({5'h00, a}, {5'h00, e});
    endtask
    // Compares a one-bit flag with its expectation.
    task automatic cmp_flag(input logic a, input logic e);
        cmp({15'h0000, a}, {15'h0000, e});
    endtask
    // Sends n encoder words, holding each until it is accepted.
    task automatic push(input int n, input logic [15:0] base);
        for (int i = 0; i < n; i++)
        begin
            ev = 1'b1;
            ed = base + 16'(i);
            exp.push_back((blk % 128 == 1) ? {ed[15:8], 8'h00} : ed);
            blk++;
            do
            begin
                acc = er;
                @(posedge clk);
                #1;
            end while (acc !== 1'b1);
        end
        ev = 1'b0;
    endtask
    // Each popped word must be the oldest one expected.
    always @(posedge got_v)
        cmp(got, exp.size() ? exp.pop_front() : 16'hdead);
    // Remembers any overflow pulse.
    always @(posedge clk)
        if (ovf === 1'b1)
            ovf_seen <= 1'b1;
    // Cuts a hang short.
    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        summarize();
    end
    // ==========================================
    // Main sequence
    // ==========================================
    initial
    begin
        repeat (10) @(posedge clk);
        #1;
        nrst = 1'b1;
        cmp({5'h00, cnt}, 16'h0000);
        srst = 1'b1;
        rec = 1'b1;
        @(posedge clk);
        #1;
        srst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        cmp({15'h0, act}, 16'h0001);
        // Fill table: count after filling, then drain in order.
        for (int r = 0; r < 3; r++)
        begin
            push(rows[r].n, rows[r].base);
            repeat (8) @(posedge clk);
            #1;
            cmp({5'h00, cnt}, {5'h00, rows[r].cnt});
            host_en = 1'b1;
            repeat (3 * rows[r].n + 4) @(posedge clk);
            #1;
            host_en = 1'b0;
            repeat (4) @(posedge clk);
            #1;
            cmp({5'h00, cnt}, 16'h0000);
            cmp(16'(exp.size()), 16'h0000);
        end
        // One word beyond capacity empties the buffer.
        push(33, 16'h4d00);
        exp.delete();
        blk = 0;
        repeat (8) @(posedge clk);
        #1;
        cmp({5'h00, cnt}, 16'h0000);
        cmp({15'h0, ovf_seen}, 16'h0001);
        // A fresh recording zeroes the fourth byte of its first block.
        srst = 1'b1;
        rec = 1'b1;
        @(posedge clk);
        #1;
        srst = 1'b0;
        blk = 0;
        push(2, 16'h5e11);
        repeat (8) @(posedge clk);
        #1;
        cmp_count(cnt, 11'h002);
        host_en = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        host_en = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        cmp_count(cnt, 11'h000);
        cmp(16'(exp.size()), 16'h0000);
        // A mid-run reset returns to idle.
        nrst = 1'b0;
        @(posedge clk);
        #1;
        nrst = 1'b1;
        cmp({15'h0, act}, 16'h0000);
        cmp_count(cnt, 11'h000);
        cmp_flag(ovf, 1'b0);
        summarize();
    end
endmodule

// file: test/arb_host_model.sv
// Host model that drains the record buffer through the data port.
`timescale 1ns/100ps
module arb_host_model
(
    // Clock and run control.
    input  wire logic        clk,
    input  wire logic        en,
    // Device data port.
    input  wire logic [15:0] word_in,
    input  wire logic [10:0] fill,
    output logic             rd,
    // Word handed to the bench.
    output logic [15:0]      got,
    output logic             got_v
);
    // ==========================================
    // Drain loop
    // ==========================================
    logic [7:0] file_first;   // Byte written to the file first.
    logic [7:0] file_second;  // Byte written to the file second.
    // Idle values at time zero.
    initial
    begin
        rd = 1'b0;
        got = 16'h0000;
        got_v = 1'b0;
        file_first = 8'h00;
        file_second = 8'h00;
    end
    // Pops one word, then waits out the count lag so it never overreads.
    // Near the top of the buffer it holds off and lets the overflow clear.
    always
    begin
        @(posedge clk);
        #1;
        if (en && fill != 11'h000 && fill < 11'h380)
        begin
            file_first = word_in[15:8];
            file_second = word_in[7:0];
            got = {file_first, file_second};
            rd = 1'b1;
            @(posedge clk);
            #1;
            rd = 1'b0;
            got_v = 1'b1;
            @(posedge clk);
            #1;
            got_v = 1'b0;
        end
    end
endmodule
